// file: verilog/gpib_result_output_buffer_consts.svh
// Constants for the instrument bus result output buffer.
// Assumes a 250 MHz core clock and a byte-wide bus handshake outside.
// Summary of operation
// - Talk-only and addressed bus modes both supported
// - Talk-only: front panel configures, bus reads
// - Each measurement end loads buffer, overwriting
// - Buffer empty once full message transferred
// - Update during transfer is postponed until done
// - Request on empty buffer waits for load
// - Resolution sets gate time and result rate
// - Hold mode: one cycle per reset key
// - Listener addressed: accept device commands
// - Talker addressed: return results over bus
// - Talker with empty buffer stalls handshake
// - Every value sent as 21 ASCII characters
// - Letters, sign, twelve mantissa places, exponent, CRLF
// - Exponent always a multiple of three
`ifndef GPIB_RESULT_OUTPUT_BUFFER_CONSTS_SVH
`define GPIB_RESULT_OUTPUT_BUFFER_CONSTS_SVH

// Clock and gate timing
`define CLK_MHZ 250
`define US_PER_MS 1000
`define GATE_R10_MS 20000
`define GATE_R9_MS 1000
`define GATE_R8_MS 100
`define GATE_R7_MS 10
`define GATE_LOW_MS 1
`define RES_10 4'hA
`define RES_9 4'h9
`define RES_8 4'h8
`define RES_7 4'h7

// Message layout
`define MSG_LAST 5'h14
`define MSG_SIGN 5'h02
`define MSG_MANT0 5'h03
`define MSG_MANT_LAST 5'h0E
`define MSG_EXP_E 5'h0F
`define MSG_EXP_SIGN 5'h10
`define MSG_EXP_TENS 5'h11
`define MSG_EXP_ONES 5'h12
`define MSG_CR_POS 5'h13
`define MANT_DIGITS 11
`define CHAR_CR 8'h0D
`define CHAR_LF 8'h0A
`define CHAR_PLUS 8'h2B
`define CHAR_MINUS 8'h2D
`define CHAR_POINT 8'h2E
`define CHAR_ZERO 8'h30
`define CHAR_E 8'h45

// Output FIFO
`define FIFO_DEPTH 4
`define FIFO_WIDTH 9

`endif

// file: verilog/result_pkg.sv
// Types of the result output buffer; its character FIFO does not use them.
// Assumes the constants header is included by each user.
`default_nettype none
package result_pkg;

	// Sender states, one-hot
	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_SEND = 3'h2,
		ST_DRAIN = 3'h4
	} sender_state_e;

	// One formatted result, exponent already a multiple of three
	typedef struct packed {
		logic [15:0] func;
		logic neg;
		logic [43:0] mant;
		logic [3:0] point;
		logic signed [6:0] exp;
	} result_s;

endpackage : result_pkg
`default_nettype wire

// file: verilog/char_fifo_if.sv
// Valid/ready carrier between the message sender and the character FIFO.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface char_fifo_if #(parameter int WIDTH = 9);
	logic [WIDTH-1:0] in_data; // Character plus last-of-message flag
	logic in_valid;
	logic in_ready;
	logic [WIDTH-1:0] out_data;
	logic out_valid;
	logic out_ready;
	modport fifo (input in_data, input in_valid, input out_ready,
		output in_ready, output out_data, output out_valid);
	modport user (output in_data, output in_valid, output out_ready,
		input in_ready, input out_data, input out_valid);
endinterface : char_fifo_if
`default_nettype wire

// file: verilog/char_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock; the drain side may stall to let it fill.
`timescale 1ns/1ps
`default_nettype none
`include "gpib_result_output_buffer_consts.svh"
module char_fifo #(
	parameter int WIDTH = `FIFO_WIDTH,
	parameter int DEPTH = `FIFO_DEPTH
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	char_fifo_if.fifo f
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] mem_reg [DEPTH]; // Storage words
	logic [WIDTH-1:0] mem_next [DEPTH];
	logic [AW-1:0] wr_reg, wr_next; // Write pointer
	logic [AW-1:0] rd_reg, rd_next; // Read pointer
	logic [AW:0] count_reg, count_next; // Words held
	logic push, pop;

	// Honest full and empty straight from the count
	assign f.in_ready = (count_reg != (AW+1)'(DEPTH));
	assign f.out_valid = (count_reg != '0);
	assign f.out_data = mem_reg[rd_reg];

	// Pointer step with wrap, depth need not be a power of two
	function automatic logic [AW-1:0] step(input logic [AW-1:0] p);
		return (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
	endfunction : step

	// Next pointers, count and storage
	always_comb begin
		push = f.in_valid && f.in_ready;
		pop = f.out_valid && f.out_ready;
		mem_next = mem_reg;
		wr_next = wr_reg;
		rd_next = rd_reg;
		count_next = count_reg;
		if (push) begin
			mem_next[wr_reg] = f.in_data;
			wr_next = step(wr_reg);
		end
		if (pop) begin
			rd_next = step(rd_reg);
		end
		if (push && !pop) begin
			count_next = (AW+1)'(count_reg + 1'b1);
		end else if (pop && !push) begin
			count_next = (AW+1)'(count_reg - 1'b1);
		end
	end

	// Register only
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_reg[i] <= '0;
			end
			wr_reg <= '0;
			rd_reg <= '0;
			count_reg <= '0;
		end else begin
			mem_reg <= mem_next;
			wr_reg <= wr_next;
			rd_reg <= rd_next;
			count_reg <= count_next;
		end
	end
endmodule : char_fifo
`default_nettype wire

// file: verilog/gpib_result_output_buffer.sv
// Result output buffer of the counter's instrument bus port.
// Assumes bus addressing and byte handshake logic on the same clock;
// panel switch, reset key and listener trigger arrive as raw pins.
`timescale 1ns/1ps
`default_nettype none
`include "gpib_result_output_buffer_consts.svh"
module gpib_result_output_buffer #(
	parameter logic [32:0] GATE_R10_CYC =
		33'(64'(`GATE_R10_MS) * 64'(`US_PER_MS) * 64'(`CLK_MHZ)),
	parameter logic [32:0] GATE_R9_CYC =
		33'(64'(`GATE_R9_MS) * 64'(`US_PER_MS) * 64'(`CLK_MHZ)),
	parameter logic [32:0] GATE_R8_CYC =
		33'(64'(`GATE_R8_MS) * 64'(`US_PER_MS) * 64'(`CLK_MHZ)),
	parameter logic [32:0] GATE_R7_CYC =
		33'(64'(`GATE_R7_MS) * 64'(`US_PER_MS) * 64'(`CLK_MHZ)),
	parameter logic [32:0] GATE_LOW_CYC =
		33'(64'(`GATE_LOW_MS) * 64'(`US_PER_MS) * 64'(`CLK_MHZ))
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_talk_only_pin,
	input wire logic i_reset_key_pin,
	input wire logic i_xfer_req_pin,
	input wire logic i_talk_addr,
	input wire logic i_listen_addr,
	input wire logic i_hold_mode,
	input wire logic [3:0] i_resolution,
	input wire logic [15:0] i_func,
	input wire logic i_neg,
	input wire logic [43:0] i_mant,
	input wire logic [3:0] i_point,
	input wire logic signed [6:0] i_exp,
	output logic [7:0] o_data,
	output logic o_valid,
	output logic o_last,
	input wire logic i_data_ready,
	output logic o_buf_full,
	output logic o_xfer_busy,
	output logic o_meas_end,
	output logic o_cmd_listen,
	output logic o_panel_only
);
	import result_pkg::*;

	// Pin synchronisers: talk-only switch, reset key, listener trigger
	logic [2:0] meta_reg, meta_next; // First stage, read only by sync
	logic [2:0] sync_reg, sync_next;
	logic key_prev_reg, key_prev_next;
	logic talk_only_s, key_s, req_s, key_edge;

	assign talk_only_s = sync_reg[0];
	assign key_s = sync_reg[1];
	assign req_s = sync_reg[2];
	assign key_edge = key_s && !key_prev_reg;

	// Next values of the synchroniser chain
	always_comb begin
		meta_next = {i_xfer_req_pin, i_reset_key_pin, i_talk_only_pin};
		sync_next = meta_reg;
		key_prev_next = key_s;
	end

	// Register only
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			meta_reg <= 3'h0;
			sync_reg <= 3'h0;
			key_prev_reg <= 1'b0;
		end else begin
			meta_reg <= meta_next;
			sync_reg <= sync_next;
			key_prev_reg <= key_prev_next;
		end
	end

	// Gate length per resolution; low resolutions share the short gate
	function automatic logic [32:0] gate_cycles(input logic [3:0] res);
		case (res)
			`RES_10: return GATE_R10_CYC;
			`RES_9: return GATE_R9_CYC;
			`RES_8: return GATE_R8_CYC;
			`RES_7: return GATE_R7_CYC;
			default: return GATE_LOW_CYC;
		endcase
	endfunction : gate_cycles

	// Measurement cycle timer
	logic [32:0] cnt_reg, cnt_next; // Cycles into the gate
	logic run_reg, run_next; // Gate running
	logic [32:0] limit;
	logic meas_end;

	assign limit = gate_cycles(i_resolution);
	// A resolution cut mid-gate ends the cycle at once instead of wrapping
	assign meas_end = run_reg && (cnt_reg >= 33'(limit - 1'b1));

	// Continuous mode reruns at once; hold waits for the key
	always_comb begin
		cnt_next = cnt_reg;
		run_next = run_reg;
		if (!run_reg) begin
			cnt_next = '0;
			run_next = !i_hold_mode || key_edge;
		end else if (meas_end) begin
			cnt_next = '0;
			run_next = !i_hold_mode;
		end else begin
			cnt_next = 33'(cnt_reg + 1'b1);
		end
	end

	// Register only
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt_reg <= '0;
			run_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			run_reg <= run_next;
		end
	end

	// Non-negative remainder of a signed exponent by three
	function automatic logic [1:0] mod3(input logic signed [6:0] e);
		int r;
		r = int'(e) % 3;
		if (r < 0) begin
			r = r + 3;
		end
		return 2'(r);
	endfunction : mod3

	// Shift the point right so the exponent drops to a multiple of three
	function automatic result_s format_result(input logic [15:0] fn,
		input logic ng, input logic [43:0] mt, input logic [3:0] pt,
		input logic signed [6:0] ex);
		result_s r;
		logic [1:0] m;
		m = mod3(ex);
		r.func = fn;
		r.neg = ng;
		r.mant = mt;
		r.point = 4'(pt + m);
		r.exp = 7'(ex - $signed({5'h00, m}));
		return r;
	endfunction : format_result

	// One message character from the buffered result
	function automatic logic [7:0] msg_char(input logic [4:0] idx,
		input result_s r);
		int p, k, a;
		p = int'(idx) - int'(`MSG_MANT0);
		a = (r.exp < 0) ? -int'(r.exp) : int'(r.exp);
		k = (p < int'(r.point)) ? p : p - 1;
		if (idx < `MSG_SIGN) begin
			return (idx == 5'h00) ? r.func[15:8] : r.func[7:0];
		end else if (idx == `MSG_SIGN) begin
			return r.neg ? `CHAR_MINUS : `CHAR_PLUS;
		end else if (idx <= `MSG_MANT_LAST) begin
			if (p == int'(r.point)) begin
				return `CHAR_POINT;
			end
			return `CHAR_ZERO |
				{4'h0, r.mant[4*(`MANT_DIGITS-1-k) +: 4]};
		end else if (idx == `MSG_EXP_E) begin
			return `CHAR_E;
		end else if (idx == `MSG_EXP_SIGN) begin
			return (r.exp < 0) ? `CHAR_MINUS : `CHAR_PLUS;
		end else if (idx == `MSG_EXP_TENS) begin
			return 8'(int'(`CHAR_ZERO) + a / 10);
		end else if (idx == `MSG_EXP_ONES) begin
			return 8'(int'(`CHAR_ZERO) + a % 10);
		end else if (idx == `MSG_CR_POS) begin
			return `CHAR_CR;
		end
		return `CHAR_LF;
	endfunction : msg_char

	// Output FIFO between sender and bus handshake
	char_fifo_if #(.WIDTH(`FIFO_WIDTH)) cf ();
	char_fifo #(.WIDTH(`FIFO_WIDTH), .DEPTH(`FIFO_DEPTH)) u_fifo (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.f(cf.fifo)
	);

	// Buffer and sender state
	sender_state_e state_reg, state_next;
	logic [4:0] idx_reg, idx_next; // Next character to queue
	logic full_reg, full_next; // Single-entry buffer holds a result
	result_s buf_reg, buf_next; // Result being offered
	logic pend_reg, pend_next; // Postponed update waiting
	result_s pend_buf_reg, pend_buf_next;
	logic talk_en, last_pop, done, busy;
	result_s fresh;

	// Talk-only needs no controller; addressed needs the talk address
	assign talk_en = talk_only_s || i_talk_addr;
	assign last_pop = cf.out_valid && cf.out_ready && cf.out_data[8];
	assign busy = (state_reg != ST_IDLE);
	assign done = (state_reg == ST_DRAIN) && last_pop;
	assign fresh = format_result(i_func, i_neg, i_mant, i_point, i_exp);
	assign cf.in_valid = (state_reg == ST_SEND);
	assign cf.in_data = {(idx_reg == `MSG_LAST), msg_char(idx_reg, buf_reg)};
	assign cf.out_ready = i_data_ready;

	// Sender walk and buffer update arbitration
	always_comb begin
		state_next = state_reg;
		idx_next = idx_reg;
		full_next = full_reg;
		buf_next = buf_reg;
		pend_next = pend_reg;
		pend_buf_next = pend_buf_reg;
		case (state_reg)
			ST_IDLE: begin
				// Only the listener's trigger starts; empty buffer waits
				if (full_reg && talk_en && req_s) begin
					state_next = ST_SEND;
					idx_next = 5'h00;
				end
			end
			ST_SEND: begin
				if (cf.in_ready) begin
					if (idx_reg == `MSG_LAST) begin
						state_next = ST_DRAIN;
					end else begin
						idx_next = 5'(idx_reg + 1'b1);
					end
				end
			end
			ST_DRAIN: begin
				// Empty only once the line feed has left the port
				if (last_pop) begin
					state_next = ST_IDLE;
					full_next = 1'b0;
				end
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
		// A new result beats the clear in the same cycle
		if (meas_end) begin
			if (busy && !done) begin
				pend_next = 1'b1;
				pend_buf_next = fresh;
			end else begin
				buf_next = fresh;
				full_next = 1'b1;
				pend_next = 1'b0;
			end
		end else if (done && pend_reg) begin
			buf_next = pend_buf_reg;
			full_next = 1'b1;
			pend_next = 1'b0;
		end
	end

	// Register only
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_reg <= ST_IDLE;
			idx_reg <= 5'h00;
			full_reg <= 1'b0;
			buf_reg <= '0;
			pend_reg <= 1'b0;
			pend_buf_reg <= '0;
		end else begin
			state_reg <= state_next;
			idx_reg <= idx_next;
			full_reg <= full_next;
			buf_reg <= buf_next;
			pend_reg <= pend_next;
			pend_buf_reg <= pend_buf_next;
		end
	end

	// Outputs
	assign o_data = cf.out_data[7:0];
	assign o_last = cf.out_data[8];
	assign o_valid = cf.out_valid;
	assign o_buf_full = full_reg;
	assign o_xfer_busy = busy;
	assign o_meas_end = meas_end;
	// Commands only when addressed to listen, never in talk-only
	assign o_cmd_listen = i_listen_addr && !talk_only_s;
	assign o_panel_only = talk_only_s;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	sequence s_start;
		(state_reg == ST_IDLE) ##1 (state_reg == ST_SEND);
	endsequence

	busy_hold_buf_a: assert property (
		busy && !done |=> $stable(buf_reg))
		else $error("buffer changed during a transfer");
	idle_load_a: assert property (
		meas_end && !busy |=> full_reg && buf_reg.mant == $past(i_mant))
		else $error("measurement end did not load the buffer");
	empty_stall_a: assert property (
		(state_reg == ST_IDLE) && !full_reg |=> state_reg == ST_IDLE)
		else $error("transfer started on an empty buffer");
	untriggered_idle_a: assert property (
		(state_reg == ST_IDLE) && !req_s |=> state_reg == ST_IDLE)
		else $error("transfer started without a trigger");
	start_first_char_a: assert property (
		s_start |-> idx_reg == 5'h00 && cf.in_data[7:0] == buf_reg.func[15:8])
		else $error("message did not open with a function letter");
	msg_end_a: assert property (
		cf.in_valid && cf.in_ready && idx_reg == `MSG_LAST
		|-> cf.in_data == {1'b1, `CHAR_LF} ##1 state_reg == ST_DRAIN)
		else $error("message length or terminator wrong");
	cr_pos_a: assert property (
		cf.in_valid && idx_reg == `MSG_CR_POS |-> cf.in_data[7:0] == `CHAR_CR)
		else $error("carriage return misplaced");
	clear_after_last_a: assert property (
		done && !meas_end && !pend_reg |=> !full_reg)
		else $error("buffer not emptied after last character");
	exp_three_a: assert property (
		full_reg |-> mod3(buf_reg.exp) == 2'h0)
		else $error("exponent not a multiple of three");
	hold_single_a: assert property (
		i_hold_mode && meas_end ##1 !key_edge |-> !run_reg)
		else $error("hold mode ran an extra cycle");
	gate_len_a: assert property (
		run_reg && $rose(run_reg) ##1 (run_reg && !meas_end)[*3]
		|-> cnt_reg == 33'h0_0000_0003)
		else $error("gate counter not advancing");
endmodule : gpib_result_output_buffer
`default_nettype wire

// file: tb/bus_listener.sv
// Listener model on the far side of the result output buffer.
// Assumes the bench says when to trigger and how fast to take.
`timescale 1ns/1ps
`default_nettype none
module bus_listener (
	input wire logic i_clk,
	input wire logic i_go,
	input wire logic i_slow,
	input wire logic i_clear,
	input wire logic [7:0] i_data,
	input wire logic i_valid,
	input wire logic i_last,
	output logic o_req,
	output logic o_ready
);
	logic [7:0] got [0:20]; // Characters of the current message
	int n = 0; // Characters taken since the bench cleared it
	int last_at = -1; // Position of the last flag
	logic [3:0] phase = 4'h0; // Pacing count for slow mode

	// Trigger comes only from this side; the device never pushes
	assign o_req = i_go;
	// Slow mode takes one character in sixteen to stretch a transfer
	assign o_ready = !i_slow || (phase == 4'hF);

	// Bytes kept raw: units follow the commanded function
	always @(posedge i_clk) begin
		phase <= phase + 4'h1;
		// Clear comes from the bench, so only this process owns the count
		if (i_clear) begin
			n <= 0;
			last_at <= -1;
		end else if (i_valid && o_ready) begin
			if (n < 21) begin
				got[n] <= i_data;
			end
			if (i_last) begin
				last_at <= n;
			end
			n <= n + 1;
		end
	end
endmodule : bus_listener
`default_nettype wire

// file: tb/testbench.sv
// Self-checking bench for the result output buffer.
// Assumes the listener model and gates cut short by parameter.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic i_clk = 1'b0; // 4 ns period
	logic i_rst_n = 1'b0;
	logic i_talk_only_pin = 1'b1; // Talk-only first
	logic i_reset_key_pin = 1'b0;
	logic i_talk_addr = 1'b0;
	logic i_listen_addr = 1'b1;
	logic i_hold_mode = 1'b0;
	logic [3:0] i_resolution = 4'hA; // Longest gate fits a message
	logic [15:0] i_func = 16'h0000;
	logic i_neg = 1'b0;
	logic [43:0] i_mant = 44'h0;
	logic [3:0] i_point = 4'h0;
	logic signed [6:0] i_exp = 7'h00;
	logic go = 1'b0; // Tells the listener to trigger
	logic slow = 1'b0; // Listener pacing
	logic clr = 1'b0; // Clears the listener's character count
	logic req, ready, o_valid, o_last, o_buf_full, o_xfer_busy;
	logic o_meas_end, o_cmd_listen, o_panel_only;
	logic [7:0] o_data;
	logic [7:0] em [0:20]; // Expected message
	int fail_count = 0;
	int compares = 0;

	// Free-running clock
	always #2 i_clk = ~i_clk;

	// Gates cut to 300, 16, 12, 8 and 5 cycles
	gpib_result_output_buffer #(.GATE_R10_CYC(33'h12C),
		.GATE_R9_CYC(33'h10), .GATE_R8_CYC(33'hC),
		.GATE_R7_CYC(33'h8), .GATE_LOW_CYC(33'h5)) dut (
		.i_clk(i_clk), .i_rst_n(i_rst_n),
		.i_talk_only_pin(i_talk_only_pin),
		.i_reset_key_pin(i_reset_key_pin), .i_xfer_req_pin(req),
		.i_talk_addr(i_talk_addr), .i_listen_addr(i_listen_addr),
		.i_hold_mode(i_hold_mode), .i_resolution(i_resolution),
		.i_func(i_func), .i_neg(i_neg), .i_mant(i_mant),
		.i_point(i_point), .i_exp(i_exp), .o_data(o_data),
		.o_valid(o_valid), .o_last(o_last), .i_data_ready(ready),
		.o_buf_full(o_buf_full), .o_xfer_busy(o_xfer_busy),
		.o_meas_end(o_meas_end), .o_cmd_listen(o_cmd_listen),
		.o_panel_only(o_panel_only));
	bus_listener lsn (.i_clk(i_clk), .i_go(go), .i_slow(slow),
		.i_clear(clr),
		.i_data(o_data), .i_valid(o_valid), .i_last(o_last),
		.o_req(req), .o_ready(ready));

	// Inputs move 1 ns after the edge, never on it
	task automatic step(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask : step

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			fail_count++;
			$display("ERROR %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk

	task automatic close_out();
		if (fail_count == 0 && compares > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : close_out

	task automatic put(input logic [15:0] f, input logic ng,
		input logic [43:0] mt, input logic [3:0] pt, input logic [6:0] ex);
		i_func = f;
		i_neg = ng;
		i_mant = mt;
		i_point = pt;
		i_exp = ex;
	endtask : put

	// Expected 21 characters from the present inputs
	task automatic make_msg();
		int pt;
		int ex;
		int k;
		ex = i_exp;
		// Non-negative remainder: the exponent only ever moves down
		pt = ex % 3;
		if (pt < 0) begin
			pt = pt + 3;
		end
		ex = ex - pt;
		pt = pt + int'(i_point);
		em[0] = i_func[15:8];
		em[1] = i_func[7:0];
		em[2] = i_neg ? 8'h2D : 8'h2B;
		k = 3;
		for (int d = 0; d < 12; d++) begin
			if (d == pt) begin
				em[k] = 8'h2E;
				k++;
			end
			if (d < 11) begin
				em[k] = {4'h3, i_mant[43 - 4 * d -: 4]};
				k++;
			end
		end
		em[15] = 8'h45;
		em[16] = (ex < 0) ? 8'h2D : 8'h2B;
		ex = (ex < 0) ? -ex : ex;
		em[17] = 8'h30 + 8'(ex / 10);
		em[18] = 8'h30 + 8'(ex % 10);
		em[19] = 8'h0D;
		em[20] = 8'h0A;
	endtask : make_msg

	// Collect one message and compare it whole
	task automatic take_msg();
		int k;
		clr = 1'b1;
		step(1);
		clr = 1'b0;
		for (k = 0; k < 2000 && lsn.n < 21; k++) begin
			step(1);
		end
		chk(lsn.n, 21);
		for (int j = 0; j < 21; j++) begin
			chk(lsn.got[j], em[j]);
		end
		chk(lsn.last_at, 20);
	endtask : take_msg

	// Returns in the cycle of the end pulse
	task automatic wait_end();
		for (int k = 0; k < 400 && o_meas_end !== 1'b1; k++) begin
			step(1);
		end
		chk(o_meas_end, 1);
	endtask : wait_end

	task automatic s_talk_only();
		put(16'h4641, 1'b0, 44'h123_4567_8901, 4'h3, 7'h07);
		make_msg();
		wait_end();
		step(1);
		chk(o_buf_full, 1);
		chk(o_panel_only, 1);
		chk(o_cmd_listen, 0);
		go = 1'b1;
		take_msg();
		go = 1'b0;
		step(1);
		chk(o_buf_full, 0);
		chk(o_xfer_busy, 0);
	endtask : s_talk_only

	// Talker addressed on an empty buffer must stall, then send
	task automatic s_stall();
		logic seen = 1'b0;
		i_talk_only_pin = 1'b0;
		step(4);
		chk(o_cmd_listen, 1);
		chk(o_panel_only, 0);
		i_listen_addr = 1'b0;
		i_talk_addr = 1'b1;
		go = 1'b1;
		repeat (30) begin
			seen = seen | o_valid;
			step(1);
		end
		chk(seen, 0);
		// Negative exponent not a multiple of three moves the point
		put(16'h5041, 1'b1, 44'h000_0000_1234, 4'h0, 7'h7C);
		make_msg();
		take_msg();
		go = 1'b0;
	endtask : s_stall

	// A gate ends while a slow transfer runs
	task automatic s_postpone();
		put(16'h4642, 1'b0, 44'h987_6543_2109, 4'h2, 7'h03);
		wait_end();
		make_msg();
		step(1);
		put(16'h5241, 1'b1, 44'h555_0000_0001, 4'h9, 7'h08);
		slow = 1'b1;
		go = 1'b1;
		take_msg();
		step(1);
		chk(o_buf_full, 1);
		chk(o_xfer_busy, 1);
		slow = 1'b0;
		make_msg();
		take_msg();
		go = 1'b0;
	endtask : s_postpone

	task automatic s_overwrite();
		put(16'h434B, 1'b0, 44'h111_1111_1111, 4'h1, 7'h00);
		wait_end();
		step(1);
		put(16'h4642, 1'b0, 44'h222_2222_2222, 4'h5, 7'h04);
		make_msg();
		wait_end();
		step(1);
		go = 1'b1;
		take_msg();
		go = 1'b0;
	endtask : s_overwrite

	// Resolution is changed on an end pulse, so no gate is cut;
	// the next gate starts right after the pulse, period equals length
	task automatic s_gate();
		logic [3:0] res [4] = '{4'h9, 4'h8, 4'h7, 4'h3};
		int len [4] = '{16, 12, 8, 5};
		int k;
		for (int j = 0; j < 4; j++) begin
			wait_end();
			i_resolution = res[j];
			step(1);
			wait_end();
			step(1);
			for (k = 1; k < 99 && o_meas_end !== 1'b1; k++) begin
				step(1);
			end
			chk(k, len[j]);
		end
	endtask : s_gate

	task automatic s_hold();
		int hits = 0;
		i_hold_mode = 1'b1;
		step(20);
		repeat (40) begin
			hits += o_meas_end;
			step(1);
		end
		chk(hits, 0);
		i_reset_key_pin = 1'b1;
		step(4);
		i_reset_key_pin = 1'b0;
		repeat (60) begin
			hits += o_meas_end;
			step(1);
		end
		chk(hits, 1);
	endtask : s_hold

	// Main sequence after 12 cycles of reset
	initial begin
		step(12);
		i_rst_n = 1'b1;
		step(1);
		chk(o_buf_full, 0);
		s_talk_only();
		s_stall();
		s_postpone();
		s_overwrite();
		s_gate();
		s_hold();
		close_out();
	end

	// Watchdog, well beyond the expected run length
	initial begin
		#60000;
		fail_count++;
		$display("ERROR %0t: watchdog expired", $time);
		close_out();
	end
endmodule : testbench
`default_nettype wire
